// ---- core/frws_defines.svh ----
// Offsets, field positions, reset values and timing counts of the row write sequencer.
`ifndef FRWS_DEFINES_SVH
`define FRWS_DEFINES_SVH
`define FRWS_OFS_ADDR_LOW 12'h000
`define FRWS_OFS_ADDR_HIGH 12'h004
`define FRWS_OFS_WORD_LOW 12'h008
`define FRWS_OFS_WORD_HIGH 12'h00C
`define FRWS_OFS_CONTROL_ONE 12'h010
`define FRWS_OFS_UNLOCK_KEY 12'h014
`define FRWS_BIT_CFG_SEL 6
`define FRWS_BIT_LATCH_ONLY 5
`define FRWS_BIT_ROW_ERASE 4
`define FRWS_BIT_WRITE_EN 2
`define FRWS_BIT_WRITE_START 1
`define FRWS_BIT_CTRL_ONE 7
`define FRWS_KEY_FIRST 8'h55
`define FRWS_KEY_SECOND 8'hAA
`define FRWS_BLANK_WORD 14'h3FFF
`define FRWS_NOP_CYCLES 2'h2
`define FRWS_CLK_PERIOD_NS 10
`define FRWS_PROG_TIME_NS 2000000
`define FRWS_PROG_CYCLES (`FRWS_PROG_TIME_NS / `FRWS_CLK_PERIOD_NS)
`endif

// ---- core/frws_pkg.sv ----
// Types shared by the row write sequencer modules.
package frws_pkg;
	typedef enum logic [1:0] {
		KEY_IDLE = 2'b00,
		KEY_GOT_FIRST = 2'b01,
		KEY_ARMED = 2'b10
	} frws_key_type;
	typedef enum logic [2:0] {
		ENG_IDLE = 3'b000,
		ENG_NOP = 3'b001,
		ENG_READ = 3'b010,
		ENG_PROG = 3'b011,
		ENG_WAIT = 3'b100,
		ENG_CLEAR = 3'b101
	} frws_eng_type;
endpackage : frws_pkg

// ---- core/frws_latch_if.sv ----
// Port bundle between the sequencer and its write latch store.
`timescale 1ns/10ps
interface frws_latch_if #(parameter int DW = 14, parameter int AW = 4);
	logic we;
	logic [AW-1:0] waddr;
	logic [DW-1:0] wdata;
	logic [AW-1:0] raddr;
	logic [DW-1:0] rdata;
	logic clr;
	modport ctrl (output we, output waddr, output wdata, output raddr, output clr, input rdata);
	modport store (input we, input waddr, input wdata, input raddr, input clr, output rdata);
endinterface : frws_latch_if

// ---- core/frws_latch_mem.sv ----
// Write latch store: one word per latch, registered read, blank on reset or clear.
`timescale 1ns/10ps
`include "frws_defines.svh"
module frws_latch_mem #(
	parameter int DEPTH = 16
) (
	// Clock and reset
	input wire logic mclk_i,
	input wire logic rst_n_i,
	// Latch access
	frws_latch_if.store lat
);
	logic [13:0] mem_r [DEPTH];

	always_ff @(posedge mclk_i)
	begin
		if (!rst_n_i || lat.clr)
		begin
			for (int i = 0; i < DEPTH; i++)
				mem_r[i] <= `FRWS_BLANK_WORD;
		end
		else if (lat.we)
			mem_r[lat.waddr] <= lat.wdata;
	end

	always_ff @(posedge mclk_i)
	begin
		if (!rst_n_i)
			lat.rdata <= `FRWS_BLANK_WORD;
		else
			lat.rdata <= mem_r[lat.raddr];
	end
endmodule : frws_latch_mem

// ---- core/frws_seq.sv ----
// Flash row write sequencer: APB registers, unlock key, latch loading and row programming.
// Notes on behaviour
// (R1) No automatic erase when programming starts.
// (R2) One program writes at most all latches.
// (R3) Row from high[6:0],low[7:5]; latch from low.
// (R4) Programming never leaves the addressed row.
// (R5) Latches return blank after every program.
// (R6) Latches return blank after every erase.
// (R7) Only complete uninterrupted unlock loads or programs.
// (R8) Latch-only set: load latch, no programming.
// (R9) Latch-only clear: load last word, program row.
// (R10) Software loads, unlocks, increments, clears latch-only last.
// (R11) Partial change: read, erase, reload, program.
// (R12) Unlock is 55h, AAh, write-start, two idle.
// (R13) Two forced idle cycles, then stall if programming.
// (R14) Latches are 14 bits, loaded only via data.
// (R15) Write-enable clear: unlock ignored, start drops.
`timescale 1ns/10ps
`include "frws_defines.svh"
module frws_seq import frws_pkg::*; #(
	parameter int LATCHES = 16,
	parameter int PROG_CYCLES = `FRWS_PROG_CYCLES
) (
	// Clock and reset
	input wire logic mclk_i,
	input wire logic rst_n_i,
	// APB slave
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [11:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	// Flash array port
	output logic flash_prog_o,
	output logic flash_erase_o,
	output logic flash_cfg_o,
	output logic [9:0] flash_row_o,
	output logic [3:0] flash_col_o,
	output logic [13:0] flash_data_o,
	// Processor stall
	output logic cpu_stall_o
);
	localparam int AW = $clog2(LATCHES);

	function automatic logic [9:0] frws_row(input logic [7:0] hi, input logic [7:0] lo);
		return {hi[6:0], lo[7:5]};
	endfunction : frws_row

	frws_latch_if #(.DW(14), .AW(AW)) lat ();

	frws_latch_mem #(.DEPTH(LATCHES)) u_mem (
		.mclk_i(mclk_i),
		.rst_n_i(rst_n_i),
		.lat(lat)
	);

	// ----------------------------------------
	// Register bus
	// ----------------------------------------
	logic [7:0] addr_low_r;
	logic [7:0] addr_high_r;
	logic [7:0] word_low_r;
	logic [5:0] word_high_r;
	logic cfg_sel_r;
	logic latch_only_r;
	logic row_erase_r;
	logic write_en_r;
	logic write_start_r;
	frws_key_type key_r;
	frws_eng_type eng_r;
	logic acc;
	logic wr;
	logic mapped;
	logic start;
	logic ctrl_wr;

	assign acc = psel_i && penable_i && pready_o;
	assign wr = acc && pwrite_i;
	assign ctrl_wr = wr && paddr_i == `FRWS_OFS_CONTROL_ONE;
	// The bus stalls while the engine runs, so the processor holds like a forced idle.
	assign pready_o = eng_r == ENG_IDLE; // R13
	assign cpu_stall_o = eng_r != ENG_IDLE;

	always_comb
	begin
		mapped = 1'b1;
		prdata_o = 32'h0;
		unique case (paddr_i)
			`FRWS_OFS_ADDR_LOW: prdata_o[7:0] = addr_low_r;
			`FRWS_OFS_ADDR_HIGH: prdata_o[7:0] = addr_high_r;
			`FRWS_OFS_WORD_LOW: prdata_o[7:0] = word_low_r;
			`FRWS_OFS_WORD_HIGH: prdata_o[5:0] = word_high_r;
			`FRWS_OFS_CONTROL_ONE: prdata_o[7:0] = {1'b1, cfg_sel_r, latch_only_r, row_erase_r,
				1'b0, write_en_r, write_start_r, 1'b0};
			`FRWS_OFS_UNLOCK_KEY: prdata_o = 32'h0;
			default: mapped = 1'b0;
		endcase
		if (!acc || pwrite_i)
			prdata_o = 32'h0;
	end
	assign pslverr_o = acc && !mapped;

	always_ff @(posedge mclk_i)
	begin
		if (!rst_n_i)
		begin
			addr_low_r <= 8'h00;
			addr_high_r <= 8'h00;
			word_low_r <= 8'h00;
			word_high_r <= 6'h00;
		end
		else if (wr)
		begin
			if (paddr_i == `FRWS_OFS_ADDR_LOW)
				addr_low_r <= pwdata_i[7:0];
			if (paddr_i == `FRWS_OFS_ADDR_HIGH)
				addr_high_r <= {1'b0, pwdata_i[6:0]}; // R3
			if (paddr_i == `FRWS_OFS_WORD_LOW)
				word_low_r <= pwdata_i[7:0];
			if (paddr_i == `FRWS_OFS_WORD_HIGH)
				word_high_r <= pwdata_i[5:0]; // R14
		end
	end

	// ----------------------------------------
	// Unlock key
	// ----------------------------------------
	// Any other write between the key steps breaks the sequence.
	always_ff @(posedge mclk_i)
	begin
		if (!rst_n_i)
			key_r <= KEY_IDLE;
		else if (wr)
		begin
			if (paddr_i == `FRWS_OFS_UNLOCK_KEY && pwdata_i[7:0] == `FRWS_KEY_FIRST)
				key_r <= KEY_GOT_FIRST; // R12
			else if (paddr_i == `FRWS_OFS_UNLOCK_KEY && pwdata_i[7:0] == `FRWS_KEY_SECOND
				&& key_r == KEY_GOT_FIRST)
				key_r <= KEY_ARMED; // R12
			else
				key_r <= KEY_IDLE; // R7
		end
	end

	assign start = ctrl_wr && pwdata_i[`FRWS_BIT_WRITE_START] && key_r == KEY_ARMED
		&& pwdata_i[`FRWS_BIT_WRITE_EN]; // R7 R15

	// ----------------------------------------
	// Control register
	// ----------------------------------------
	logic [1:0] nop_cnt_r;
	logic done;
	assign done = eng_r == ENG_CLEAR || (eng_r == ENG_NOP && nop_cnt_r == `FRWS_NOP_CYCLES
		&& latch_only_r && !row_erase_r);

	always_ff @(posedge mclk_i)
	begin
		if (!rst_n_i)
		begin
			cfg_sel_r <= 1'b0;
			latch_only_r <= 1'b0;
			row_erase_r <= 1'b0;
			write_en_r <= 1'b0;
		end
		else if (ctrl_wr)
		begin
			cfg_sel_r <= pwdata_i[`FRWS_BIT_CFG_SEL];
			latch_only_r <= pwdata_i[`FRWS_BIT_LATCH_ONLY];
			row_erase_r <= pwdata_i[`FRWS_BIT_ROW_ERASE];
			write_en_r <= pwdata_i[`FRWS_BIT_WRITE_EN];
		end
		else if (eng_r == ENG_CLEAR)
			row_erase_r <= 1'b0;
	end

	// Start can only be set by a valid unlock; it drops when the operation ends.
	always_ff @(posedge mclk_i)
	begin
		if (!rst_n_i)
			write_start_r <= 1'b0;
		else if (start)
			write_start_r <= 1'b1; // R15
		else if (done)
			write_start_r <= 1'b0;
	end

	// ----------------------------------------
	// Latch loading
	// ----------------------------------------
	assign lat.we = start && !pwdata_i[`FRWS_BIT_ROW_ERASE]; // R8 R9
	assign lat.waddr = addr_low_r[AW-1:0]; // R3
	assign lat.wdata = {word_high_r, word_low_r}; // R14
	assign lat.clr = eng_r == ENG_CLEAR; // R5 R6

	// ----------------------------------------
	// Program engine
	// ----------------------------------------
	logic [AW-1:0] col_r;
	logic [$clog2(PROG_CYCLES+1)-1:0] wait_r;
	logic [9:0] row_r;

	assign lat.raddr = col_r;

	always_ff @(posedge mclk_i)
	begin
		if (!rst_n_i)
			row_r <= 10'h000;
		else if (start)
			row_r <= frws_row(addr_high_r, addr_low_r); // R3 R4
	end

	always_ff @(posedge mclk_i)
	begin
		if (!rst_n_i)
		begin
			eng_r <= ENG_IDLE;
			nop_cnt_r <= 2'h0;
			col_r <= '0;
			wait_r <= '0;
		end
		else
		begin
			unique case (eng_r)
				ENG_IDLE:
					if (start)
					begin
						eng_r <= ENG_NOP; // R13
						nop_cnt_r <= 2'h1;
						wait_r <= '0;
					end
				ENG_NOP:
					if (nop_cnt_r != `FRWS_NOP_CYCLES)
						nop_cnt_r <= nop_cnt_r + 2'h1;
					else if (row_erase_r)
						eng_r <= ENG_WAIT; // R6
					else if (latch_only_r)
						eng_r <= ENG_IDLE; // R8
					else
					begin
						eng_r <= ENG_READ; // R9
						col_r <= '0;
					end
				ENG_READ:
					eng_r <= ENG_PROG;
				ENG_PROG:
				begin
					// The column wraps inside the row and the row register is frozen.
					col_r <= col_r + 1'b1; // R4
					eng_r <= (col_r == AW'(LATCHES - 1)) ? ENG_WAIT : ENG_READ; // R2
					wait_r <= '0;
				end
				ENG_WAIT:
					if (wait_r == ($bits(wait_r))'(PROG_CYCLES - 1))
						eng_r <= ENG_CLEAR; // R13
					else
						wait_r <= wait_r + 1'b1;
				ENG_CLEAR:
					eng_r <= ENG_IDLE; // R5 R6
				default:
					eng_r <= ENG_IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// Flash array port
	// ----------------------------------------
	always_ff @(posedge mclk_i)
	begin
		if (!rst_n_i)
		begin
			flash_prog_o <= 1'b0;
			flash_erase_o <= 1'b0;
			flash_cfg_o <= 1'b0;
			flash_row_o <= 10'h000;
			flash_col_o <= 4'h0;
			flash_data_o <= `FRWS_BLANK_WORD;
		end
		else
		begin
			flash_prog_o <= eng_r == ENG_PROG; // R9
			flash_erase_o <= eng_r == ENG_NOP && nop_cnt_r == `FRWS_NOP_CYCLES
				&& row_erase_r; // R1
			flash_cfg_o <= cfg_sel_r;
			flash_row_o <= row_r; // R4
			flash_col_o <= 4'(col_r);
			flash_data_o <= lat.rdata;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	logic [5:0] prog_cnt_r;
	always_ff @(posedge mclk_i)
	begin
		if (!rst_n_i || eng_r == ENG_IDLE)
			prog_cnt_r <= 6'h00;
		else if (flash_prog_o)
			prog_cnt_r <= prog_cnt_r + 6'h01;
	end

	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!rst_n_i);

	key_armed_a: assert property ($rose(write_start_r) |-> $past(key_r) == KEY_ARMED) // R7
		else $error("start set without complete unlock");
	write_enable_bit_block_a: assert property (ctrl_wr && !pwdata_i[`FRWS_BIT_WRITE_EN] |=> // R15
		!write_start_r && eng_r == ENG_IDLE) else $error("start taken with writes disabled");
	latch_only_a: assert property (start && pwdata_i[`FRWS_BIT_LATCH_ONLY] // R8
		&& !pwdata_i[`FRWS_BIT_ROW_ERASE] |-> lat.we ##1 !pready_o [*2] ##1 pready_o
		&& !flash_prog_o) else $error("latch only load misbehaved");
	nop_two_a: assert property (start |=> cpu_stall_o [*2]) // R13
		else $error("forced idle cycles missing");
	prog_max_a: assert property (prog_cnt_r <= 6'(LATCHES)) // R2
		else $error("more words programmed than latches");
	row_hold_a: assert property (flash_prog_o |-> flash_row_o == row_r // R4
		&& $stable(row_r)) else $error("programming left the row");
	no_erase_a: assert property (start && !pwdata_i[`FRWS_BIT_ROW_ERASE] |=> // R1
		!flash_erase_o throughout (eng_r != ENG_IDLE)[*2]) else $error("erase during program");
	prog_go_a: assert property (start && !pwdata_i[`FRWS_BIT_LATCH_ONLY] // R9
		&& !pwdata_i[`FRWS_BIT_ROW_ERASE] |-> lat.we ##3 eng_r == ENG_READ)
		else $error("program did not follow final load");
	blank_end_a: assert property ($fell(cpu_stall_o) && $past(eng_r) != ENG_NOP // R5
		|-> $past(lat.clr)) else $error("latches not blanked after program");
	latch_addr_a: assert property (lat.we |=> // R3
		u_mem.mem_r[$past(lat.waddr)] == $past(lat.wdata)) else $error("wrong latch selected");
endmodule : frws_seq

// ---- verif/frws_flash_model.sv ----
// Behavioural flash array that records what the sequencer programs and erases.
`timescale 1ns/10ps
module frws_flash_model (
	// Clock
	input wire logic mclk_i,
	// Flash array port
	input wire logic prog_i,
	input wire logic erase_i,
	input wire logic [9:0] row_i,
	input wire logic [3:0] col_i,
	input wire logic [13:0] data_i
);
	// Words start at zero so that stray writes and missing erases both show.
	logic [13:0] mem [0:16383];
	int prog_cnt = 0;
	int erase_cnt = 0;
	initial
	begin
		foreach (mem[i]) mem[i] = 14'h0000;
	end
	always @(posedge mclk_i)
	begin
		if (prog_i === 1'b1)
		begin
			mem[{row_i, col_i}] <= data_i;
			prog_cnt++;
		end
		if (erase_i === 1'b1)
		begin
			for (int i = 0; i < 16; i++) mem[{row_i, i[3:0]}] <= 14'h3FFF;
			erase_cnt++;
		end
	end
endmodule : frws_flash_model

// ---- verif/tb.sv ----
// Self-checking bench for the row write sequencer.
`timescale 1ns/10ps
`include "frws_defines.svh"
`define CHK(nm, ex, gt) begin num_checks++; if ((gt) !== (ex)) begin err_total++; \
	$display("CHECK FAILED %s exp %0h got %0h", nm, ex, gt); end end
module tb;
	logic mclk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata_o;
	logic pready_o, pslverr_o, prog, erase, cpu_stall_o, cfg;
	logic [9:0] row;
	logic [3:0] col;
	logic [13:0] fdata;
	logic [31:0] rd;
	logic se;
	logic [13:0] ex [16];
	int err_total = 0;
	int num_checks = 0;
	int stall_cnt = 0;
	int s0;
	frws_seq #(.LATCHES(16), .PROG_CYCLES(8)) i_dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
		.psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
		.pwdata_i(pwdata), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
		.flash_prog_o(prog), .flash_erase_o(erase), .flash_cfg_o(cfg), .flash_row_o(row),
		.flash_col_o(col), .flash_data_o(fdata), .cpu_stall_o(cpu_stall_o));
	frws_flash_model i_flash (.mclk_i(mclk_i), .prog_i(prog), .erase_i(erase), .row_i(row),
		.col_i(col), .data_i(fdata));
	initial
	begin
		forever #5 mclk_i = ~mclk_i;
	end
	always @(posedge mclk_i) if (cpu_stall_o === 1'b1) stall_cnt++;
	// ----------------------------------------
	// Bus access, row check and verdict tasks
	// ----------------------------------------
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk_i);
		penable <= 1'b1;
		@(posedge mclk_i);
		while (pready_o !== 1'b1) @(posedge mclk_i);
		rd = prdata_o;
		se = pslverr_o;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge mclk_i);
	endtask : apb
	task automatic unlock(input logic [7:0] c);
		apb(1'b1, `FRWS_OFS_UNLOCK_KEY, 32'h55);
		apb(1'b1, `FRWS_OFS_UNLOCK_KEY, 32'hAA);
		apb(1'b1, `FRWS_OFS_CONTROL_ONE, {24'h0, c | 8'h02});
	endtask : unlock
	task automatic load(input logic [7:0] hi, input logic [7:0] lo, input logic [13:0] w,
		input logic [7:0] c);
		apb(1'b1, `FRWS_OFS_ADDR_HIGH, {24'h0, hi});
		apb(1'b1, `FRWS_OFS_ADDR_LOW, {24'h0, lo});
		apb(1'b1, `FRWS_OFS_WORD_LOW, {24'h0, w[7:0]});
		apb(1'b1, `FRWS_OFS_WORD_HIGH, {26'h0, w[13:8]});
		unlock(c);
		ex[lo[3:0]] = w;
	endtask : load
	task automatic check_row(input logic [9:0] r);
		for (int i = 0; i < 16; i++) `CHK("row word", ex[i], i_flash.mem[{r, i[3:0]}])
	endtask : check_row
	task automatic print_verdict();
		$display("checks %0d errors %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : print_verdict
	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial
	begin
		repeat (16) @(posedge mclk_i);
		rst_n_i <= 1'b1;
		@(posedge mclk_i);
		apb(1'b0, `FRWS_OFS_CONTROL_ONE, 32'h0);
		`CHK("control reset", 32'h80, rd)
		apb(1'b0, 12'h018, 32'h0);
		`CHK("unmapped error", 1'b1, se)
		apb(1'b1, `FRWS_OFS_CONTROL_ONE, 32'h40);
		@(posedge mclk_i);
		`CHK("config out", 1'b1, cfg)
		foreach (ex[i]) ex[i] = 14'h3FFF;
		apb(1'b1, `FRWS_OFS_CONTROL_ONE, 32'h24);
		s0 = stall_cnt;
		for (int i = 0; i < 3; i++) load(8'h05, 8'h40 | i[7:0], 14'h1230 + i[13:0], 8'h24);
		repeat (4) @(posedge mclk_i);
		`CHK("latch stall", 6, stall_cnt - s0)
		`CHK("no program", 0, i_flash.prog_cnt)
		apb(1'b0, `FRWS_OFS_CONTROL_ONE, 32'h0);
		`CHK("start cleared", 32'hA4, rd)
		apb(1'b1, `FRWS_OFS_CONTROL_ONE, 32'h04);
		load(8'h05, 8'h43, 14'h2ABC, 8'h04);
		apb(1'b0, `FRWS_OFS_CONTROL_ONE, 32'h0);
		`CHK("prog count", 16, i_flash.prog_cnt)
		`CHK("no erase", 0, i_flash.erase_cnt)
		check_row(10'd42);
		`CHK("next row", 14'h0000, i_flash.mem[{10'd43, 4'h0}])
		apb(1'b1, `FRWS_OFS_UNLOCK_KEY, 32'h55);
		apb(1'b1, `FRWS_OFS_ADDR_LOW, 32'h40);
		apb(1'b1, `FRWS_OFS_UNLOCK_KEY, 32'hAA);
		apb(1'b1, `FRWS_OFS_CONTROL_ONE, 32'h06);
		repeat (6) @(posedge mclk_i);
		`CHK("broken unlock", 16, i_flash.prog_cnt)
		unlock(8'h00);
		apb(1'b0, `FRWS_OFS_CONTROL_ONE, 32'h0);
		`CHK("disabled start", 32'h80, rd)
		`CHK("disabled prog", 16, i_flash.prog_cnt)
		foreach (ex[i]) ex[i] = 14'h3FFF;
		apb(1'b1, `FRWS_OFS_CONTROL_ONE, 32'h24);
		load(8'h7F, 8'hE0, 14'h0111, 8'h24);
		ex[0] = 14'h3FFF;
		apb(1'b1, `FRWS_OFS_CONTROL_ONE, 32'h14);
		unlock(8'h14);
		apb(1'b0, `FRWS_OFS_CONTROL_ONE, 32'h0);
		`CHK("erase done", 32'h84, rd)
		`CHK("erase count", 1, i_flash.erase_cnt)
		apb(1'b1, `FRWS_OFS_CONTROL_ONE, 32'h04);
		load(8'h7F, 8'hEF, 14'h1555, 8'h04);
		apb(1'b0, `FRWS_OFS_CONTROL_ONE, 32'h0);
		check_row(10'h3FF);
		`CHK("config off", 1'b0, cfg)
		print_verdict();
	end
	initial
	begin
		#500000;
		err_total++;
		print_verdict();
	end
endmodule : tb
